/* acf_defines.vh */
// Operation
// - Enable bit 7 gates all comparisons; disabled comparator held in low power.
// - Bit 6 picks non-inverting source: 0 positive pin, 1 bandgap reference.
// - Negative pin always inverting; positive pin used only when select is 0.
// - Bandgap selected releases the positive pin for general-purpose use.
// - Result high when non-inverting input exceeds inverting input, else low.
// - Event flag bit 5 sets on each compare event chosen by mode.
// - Writing 1 clears the event flag; writing 0 leaves it alone.
// - Mode bits 1:0: 00/10 falling, 01 rising, 11 either edge.
// - Interrupt request high exactly while enable bit 4 and flag both set; the code registers eventIrq, so it follows them one cycle late.
// - Interrupt enable is a plain read-write bit.
// - Bit 3 reads the present comparator result.
// - Result status resets to 0 and reads 0 while disabled.
// - In wait mode the block runs normally and can wake the processor.
// - In stop mode no edge detection or flag setting happens.
// - After the two deepest stop modes all state is at reset.
// - After the lightest stop mode state is kept and operation resumes.
// - In background debug halt the block keeps comparing and flagging.
`ifndef ACF_DEFINES_VH
`define ACF_DEFINES_VH
`define ACF_ADDR_W 3
`define ACF_ADDR_CTRL 3'h0
`define ACF_ADDR_STAT 3'h1
`define ACF_ADDR_MASK 3'h2
`define ACF_BIT_EN 7
`define ACF_BIT_BGS 6
`define ACF_BIT_FLAG 5
`define ACF_BIT_IE 4
`define ACF_BIT_RES 3
`define ACF_MODE_HI 1
`define ACF_MODE_LO 0
`define ACF_CTRL_RESET 8'h00
`define ACF_MODE_RISE 2'h1
`define ACF_MODE_BOTH 2'h3
`define ACF_EVT_W 2
`define ACF_EVT_COMPARE 0
`define ACF_EVT_RESULT 1
`endif

/* acf_sync.v */
`timescale 1ns/1ps
`include "acf_defines.vh"
module acf_sync
(
	input wire mclk,
	input wire reset,
	input wire clkEnable,
	input wire asyncIn,
	output reg syncOut
);
	reg stageOne;

	// First stage feeds only the second
	always @(posedge mclk)
	begin
		if (reset)
		begin
			stageOne <= 1'b0;
			syncOut <= 1'b0;
		end
		else if (clkEnable)
		begin
			stageOne <= asyncIn;
			syncOut <= stageOne;
		end
	end
endmodule

/* acf_edge_detect.v */
`timescale 1ns/1ps
`include "acf_defines.vh"
module acf_edge_detect
(
	input wire mclk,
	input wire reset,
	input wire clkEnable,
	input wire level,
	input wire [1:0] flagModeSelect,
	output wire compareEvent
);
	reg lastLevel;
	wire rise;
	wire fall;

	assign rise = clkEnable & level & ~lastLevel;
	assign fall = clkEnable & ~level & lastLevel;
	assign compareEvent = (flagModeSelect == `ACF_MODE_BOTH) ? (rise | fall) :
		(flagModeSelect == `ACF_MODE_RISE) ? rise : fall;

	always @(posedge mclk)
	begin
		if (reset)
			lastLevel <= 1'b0;
		else if (clkEnable)
			lastLevel <= level;
	end
endmodule

/* acf_comparator_ctrl.v */
// Strobed register access and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "acf_defines.vh"
module acf_comparator_ctrl
(
	input wire mclk,
	input wire reset,
	input wire deepStopWake,
	input wire stopMode,
	input wire analogResult,
	input wire [`ACF_ADDR_W-1:0] regAddr,
	input wire [7:0] regWriteData,
	input wire regWrite,
	input wire regRead,
	output reg [7:0] regReadData,
	output reg comparatorEnable,
	output reg referenceSourceSelect,
	output reg positivePinRelease,
	output reg eventIrq,
	output reg combinedIrq
);
	// ---------------------------------------------------------------
	// Control state
	// ---------------------------------------------------------------
	reg compareEventFlag;
	reg eventInterruptEnable;
	reg [1:0] flagModeSelect;
	reg [`ACF_EVT_W-1:0] eventStatus;
	reg [`ACF_EVT_W-1:0] eventMask;
	reg prevResultStatus;
	wire blockReset;
	wire clkEnable;
	wire syncResult;
	wire compareEvent;
	wire comparatorResultStatus;
	wire [`ACF_EVT_W-1:0] eventHit;
	wire [`ACF_EVT_W-1:0] next_eventStatus;
	wire [7:0] ctrlView;
	wire writeCtrl;
	wire readStat;

	// Deep stop recovery looks like a fresh reset
	assign blockReset = reset | deepStopWake;
	// Stop halts the block clock; wait and debug halt do not reach here
	assign clkEnable = ~stopMode & comparatorEnable;
	assign writeCtrl = regWrite & (regAddr == `ACF_ADDR_CTRL);
	assign readStat = regRead & (regAddr == `ACF_ADDR_STAT);

	// ---------------------------------------------------------------
	// Result path
	// ---------------------------------------------------------------
	acf_sync resultSync
	(
		.mclk(mclk),
		.reset(blockReset),
		.clkEnable(clkEnable),
		.asyncIn(analogResult),
		.syncOut(syncResult)
	);

	acf_edge_detect edgeDetect
	(
		.mclk(mclk),
		.reset(blockReset),
		.clkEnable(clkEnable),
		.level(syncResult),
		.flagModeSelect(flagModeSelect),
		.compareEvent(compareEvent)
	);

	assign comparatorResultStatus = comparatorEnable & syncResult;

	assign ctrlView = {comparatorEnable, referenceSourceSelect,
		compareEventFlag, eventInterruptEnable, comparatorResultStatus,
		1'b0, flagModeSelect};

	// ---------------------------------------------------------------
	// Control register
	// ---------------------------------------------------------------
	always @(posedge mclk)
	begin
		if (blockReset)
		begin
			comparatorEnable <= 1'b0;
			referenceSourceSelect <= 1'b0;
			eventInterruptEnable <= 1'b0;
			flagModeSelect <= 2'h0;
			compareEventFlag <= 1'b0;
		end
		else
		begin
			if (writeCtrl)
			begin
				comparatorEnable <= regWriteData[`ACF_BIT_EN];
				referenceSourceSelect <= regWriteData[`ACF_BIT_BGS];
				eventInterruptEnable <= regWriteData[`ACF_BIT_IE];
				flagModeSelect <= regWriteData[`ACF_MODE_HI:`ACF_MODE_LO];
			end
			// Set wins over a same-cycle clear
			if (compareEvent)
				compareEventFlag <= 1'b1;
			else if (writeCtrl && regWriteData[`ACF_BIT_FLAG])
				compareEventFlag <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Sticky status, cleared by reading it
	// ---------------------------------------------------------------
	assign eventHit[`ACF_EVT_COMPARE] = compareEvent;
	assign eventHit[`ACF_EVT_RESULT] = comparatorResultStatus ^
		prevResultStatus;

	// Set wins over a read clear in the same cycle
	genvar i;
	generate
		for (i = 0; i < `ACF_EVT_W; i = i + 1)
		begin : stickyBits
			assign next_eventStatus[i] = eventHit[i] |
				(eventStatus[i] & ~readStat);
		end
	endgenerate

	always @(posedge mclk)
	begin
		if (blockReset)
		begin
			eventStatus <= {`ACF_EVT_W{1'b0}};
			eventMask <= {`ACF_EVT_W{1'b0}};
			prevResultStatus <= 1'b0;
		end
		else
		begin
			eventStatus <= next_eventStatus;
			prevResultStatus <= comparatorResultStatus;
			if (regWrite && regAddr == `ACF_ADDR_MASK)
				eventMask <= regWriteData[`ACF_EVT_W-1:0];
		end
	end

	// ---------------------------------------------------------------
	// Outputs, all registered
	// ---------------------------------------------------------------
	always @(posedge mclk)
	begin
		if (blockReset)
		begin
			regReadData <= `ACF_CTRL_RESET;
			positivePinRelease <= 1'b0;
			eventIrq <= 1'b0;
			combinedIrq <= 1'b0;
		end
		else
		begin
			// Pin freed for GPIO while bandgap feeds the + input
			positivePinRelease <= referenceSourceSelect;
			// One cycle lag behind flag and enable
			eventIrq <= compareEventFlag & eventInterruptEnable;
			combinedIrq <= |(eventStatus & eventMask);
			regReadData <= 8'h00;
			if (regRead)
			begin
				case (regAddr)
					`ACF_ADDR_CTRL: regReadData <= ctrlView;
					`ACF_ADDR_STAT: regReadData <= {6'h00, eventStatus};
					`ACF_ADDR_MASK: regReadData <= {6'h00, eventMask};
					default: regReadData <= 8'h00;
				endcase
			end
		end
	end
endmodule

/* acf_props.sv */
`timescale 1ns/1ps
`include "acf_defines.vh"
module acf_props
(
	input wire mclk,
	input wire reset,
	input wire deepStopWake,
	input wire stopMode,
	input wire [`ACF_ADDR_W-1:0] regAddr,
	input wire [7:0] regWriteData,
	input wire regWrite,
	input wire regRead,
	input wire [7:0] regReadData,
	input wire comparatorEnable,
	input wire referenceSourceSelect,
	input wire positivePinRelease,
	input wire eventIrq
);
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	sequence s_wr;
		regWrite && regAddr == 3'h0 && !deepStopWake;
	endsequence
	// Four cycles so a sync change just before stop has landed
	sequence s_stop;
		(stopMode && !regWrite) [*4];
	endsequence
	a_read_slot: assert property (
		!$past(regRead) |-> regReadData == 8'h00) else $error("slot");
	a_result_off: assert property (
		regRead && regAddr == 3'h0 && !comparatorEnable |=> !regReadData[3])
		else $error("res");
	a_ctrl_write: assert property (s_wr |=>
		comparatorEnable == $past(regWriteData[7]) &&
		referenceSourceSelect == $past(regWriteData[6])) else $error("wr");
	a_pin_free: assert property (
		!$past(deepStopWake) && !$past(reset) |->
		positivePinRelease == $past(referenceSourceSelect)) else $error("pin");
	a_irq_off: assert property (
		(s_wr ##0 !regWriteData[4]) |=> ##1 !eventIrq) else $error("irq");
	a_stop_hold: assert property (s_stop |-> !$rose(eventIrq))
		else $error("stop");
	a_deep_wake: assert property (deepStopWake |=>
		!comparatorEnable && !referenceSourceSelect && !eventIrq)
		else $error("wake");
	a_ie_back: assert property (s_wr ##1 regRead && regAddr == 3'h0
		|=> regReadData[4] == $past(regWriteData[4], 2)) else $error("ie");
endmodule
bind acf_comparator_ctrl acf_props u_props(.mclk(mclk), .reset(reset),
	.deepStopWake(deepStopWake), .stopMode(stopMode), .regAddr(regAddr),
	.regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
	.regReadData(regReadData), .comparatorEnable(comparatorEnable),
	.referenceSourceSelect(referenceSourceSelect),
	.positivePinRelease(positivePinRelease), .eventIrq(eventIrq));

/* acf_analog_model.sv */
`timescale 1ns/1ps
module acf_analog_model
(
	input wire [7:0] posLevel,
	input wire [7:0] negLevel,
	input wire sourceSelect,
	output wire analogResult
);
	// Reference level arbitrary; only its ordering matters
	assign analogResult = (sourceSelect ? 8'h80 : posLevel) > negLevel;
endmodule

/* tb_acf_comparator_ctrl.sv */
`timescale 1ns/1ps
module tb_acf_comparator_ctrl;
	reg mclk = 0, reset = 1, deepStopWake = 0, stopMode = 0;
	reg regWrite = 0, regRead = 0, flag = 0, seen = 0, st = 0, lvl;
	reg rc = 0, rs = 0;
	reg [2:0] regAddr = 0;
	reg [7:0] regWriteData = 0, posLevel = 0, negLevel = 0, ctrl = 0;
	reg [15:0] r = 16'h0a18, w;
	wire res, sel, eventIrq, combinedIrq, en, pinFree;
	wire [7:0] regReadData;
	integer n_errors = 0, checks = 0, cyc = 0, i;
	acf_comparator_ctrl u_dut(.mclk(mclk), .reset(reset),
		.deepStopWake(deepStopWake), .stopMode(stopMode), .analogResult(res),
		.regAddr(regAddr), .regWriteData(regWriteData), .regWrite(regWrite),
		.regRead(regRead), .regReadData(regReadData), .comparatorEnable(en),
		.referenceSourceSelect(sel), .positivePinRelease(pinFree),
		.eventIrq(eventIrq), .combinedIrq(combinedIrq));
	acf_analog_model u_pins(.posLevel(posLevel), .negLevel(negLevel),
		.sourceSelect(sel), .analogResult(res));
	initial forever #10 mclk = ~mclk;
	function [15:0] rnd();
		r = r[0] ? (r >> 1) ^ 16'hb400 : r >> 1;
		rnd = r;
	endfunction
	function [7:0] ex();
		ex = {ctrl[7:4], ctrl[7] & seen, 1'b0, ctrl[1:0]};
	endfunction
	task give_verdict;
	begin
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	end
	endtask
	task chk(input [7:0] got, input [7:0] exp);
	begin
		checks = checks + 1;
		if (got !== exp)
		begin
			n_errors = n_errors + 1;
			$display("unexpected %0t %h %h", $time, got, exp);
		end
	end
	endtask
	task wr(input [2:0] a, input [7:0] d);
	begin
		regAddr <= a;
		regWriteData <= d;
		regWrite <= 1;
		@(posedge mclk);
		regWrite <= 0;
	end
	endtask
	task rd(input [2:0] a, input [7:0] exp, input [7:0] m);
	begin
		regAddr <= a;
		regRead <= 1;
		@(posedge mclk);
		regRead <= 0;
		#1 chk(regReadData & m, exp);
		@(posedge mclk);
	end
	endtask
	// Any change of the readable result sets the result-change status bit
	task note_rs;
	begin
		rc = rc | (rs != (ctrl[7] & seen));
		rs = ctrl[7] & seen;
	end
	endtask
	task settle;
	begin
		repeat (6) @(posedge mclk);
		note_rs;
		lvl = (ctrl[6] ? 8'h80 : posLevel) > negLevel;
		if (ctrl[7] && !stopMode && lvl != seen)
		begin
			// Mode 0 and 2 both mean falling
			if (ctrl[1:0] == 3 || (ctrl[1:0] == 1) == lvl)
				{flag, st} = 2'b11;
			seen = lvl;
		end
		note_rs;
	end
	endtask
	always @(posedge mclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			n_errors = n_errors + 1;
			give_verdict;
		end
	end
	initial
	begin
		repeat (3) @(posedge mclk);
		reset <= 0;
		rd(3'h0, 8'h00, 8'hff);
		wr(3'h5, 8'hff);
		rd(3'h5, 8'h00, 8'hff);
		wr(3'h2, 8'h01);
		rd(3'h2, 8'h01, 8'hff);
		for (i = 0; i < 80; i = i + 1)
		begin
			w = rnd();
			wr(3'h0, w[7:0]);
			ctrl = w[7:0] & 8'hd3;
			flag = flag & !w[5];
			rd(3'h0, ex() | flag << 5, 8'hff);
			// Source or enable change lands before the levels move
			settle;
			w = rnd();
			posLevel <= w[7:0];
			negLevel <= w[15:8];
			stopMode <= w[3] & w[4];
			settle;
			chk(eventIrq, flag & ctrl[4]);
			chk(combinedIrq, st);
			chk(en, ctrl[7]);
			chk(pinFree, ctrl[6]);
			rd(3'h0, ex() | flag << 5, 8'hff);
			rd(3'h1, {rc, st}, 8'h03);
			st = 0;
			rc = 0;
			stopMode <= 0;
			settle;
		end
		wr(3'h0, 8'hd3);
		deepStopWake <= 1;
		@(posedge mclk);
		deepStopWake <= 0;
		rd(3'h0, 8'h00, 8'hff);
		rd(3'h2, 8'h00, 8'hff);
		give_verdict;
	end
endmodule
